/* File: inc/cfg_latch_pkg.sv */
/*
 * Shared constants and carriers for the reset configuration latch block:
 * register indices, field positions, factory defaults, decode codes and
 * the packed structs that carry pin, debug and flash signals.
 * Assumes a single MCLK domain; nothing here holds logic.
 */
package cfg_latch_pkg;

    localparam int          NUM_LATCH      = 4;
    localparam int          NUM_PORTS      = 9;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          WCNT_W         = 8;

    // Register indices (plain port, address equals index)
    localparam logic [7:0]  IDX_DRIVE_LOW  = 8'h00;
    localparam logic [7:0]  IDX_DRIVE_HIGH = 8'h01;
    localparam logic [7:0]  IDX_RST_DBG    = 8'h02;
    localparam logic [7:0]  IDX_BOOT_ECC   = 8'h03;
    localparam logic [7:0]  IDX_STATUS     = 8'h04;
    localparam logic [7:0]  IDX_WCOUNT     = 8'h05;

    // Byte 2 fields
    localparam int          EXT_RST_BIT    = 7;
    localparam int          DBG_EN_BIT     = 6;
    localparam logic [7:0]  RST_DBG_WMASK  = 8'hC3;

    // Byte 3 fields
    localparam int          PHS_HI         = 7;
    localparam int          PHS_LO         = 4;
    localparam int          ECC_EN_BIT     = 3;
    localparam int          DPS_HI         = 2;
    localparam int          DPS_LO         = 1;
    localparam int          BOOT_SPD_BIT   = 0;

    localparam int          STAT_PEND_BIT  = 0;

    // Factory defaults
    localparam logic [7:0]  DEF_DRIVE_LOW  = 8'h00;
    localparam logic [7:0]  DEF_DRIVE_HIGH = 8'h00;
    localparam logic [7:0]  DEF_RST_DBG    = 8'h40;
    localparam logic [7:0]  DEF_BOOT_ECC   = 8'h0A;

    // Port reset drive mode codes
    localparam logic [1:0]  DRV_HIZ_ANALOG = 2'h0;
    localparam logic [1:0]  DRV_HIZ_DIG    = 2'h1;
    localparam logic [1:0]  DRV_PULL_UP    = 2'h2;
    localparam logic [1:0]  DRV_PULL_DOWN  = 2'h3;

    // Debug port select codes
    localparam logic [1:0]  DPS_JTAG5      = 2'h0;
    localparam logic [1:0]  DPS_JTAG4      = 2'h1;
    localparam logic [1:0]  DPS_SWD        = 2'h2;
    localparam logic [1:0]  DPS_OFF        = 2'h3;

    // Boot clock rates in MHz
    localparam int          BOOT_SLOW_MHZ  = 12;
    localparam int          BOOT_FAST_MHZ  = 48;

    // Flash word with check byte
    localparam int          FL_DATA_W      = 64;
    localparam int          FL_ECC_W       = 8;
    localparam int          FL_CW_W        = 72;
    localparam int          FL_SYN_W       = 7;

    typedef struct packed {
        logic analog_hiz;
        logic digital_in;
        logic pull_up;
        logic pull_down;
    } drive_ctl_t;

    typedef struct packed {
        logic jtag5;
        logic jtag4;
        logic swd;
    } dbg_ports_t;

    typedef struct packed {
        logic                 valid;
        logic [FL_DATA_W-1:0] data;
        logic [FL_ECC_W-1:0]  ecc;
    } flash_word_t;

    typedef struct packed {
        logic                 valid;
        logic [FL_DATA_W-1:0] data;
        logic                 corrected;
        logic                 dual_err;
    } flash_rsp_t;

endpackage

/* File: verilog/drive_mode_decode.sv */
/*
 * One port's reset drive mode decoder: turns a two-bit mode code into
 * registered pad controls, exactly one of which is high.
 * Assumes mode comes from flops on the same clock.
 */
`timescale 1ns/100ps

module drive_mode_decode (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic [1:0]               mode,
    output cfg_latch_pkg::drive_ctl_t     ctl
);

    cfg_latch_pkg::drive_ctl_t ctl_r;
    cfg_latch_pkg::drive_ctl_t ctl_nxt;

    always_comb begin
        ctl_nxt = '0;
        if (!rst_b) begin
            ctl_nxt.analog_hiz = 1'b1;
        end else if (mode == cfg_latch_pkg::DRV_HIZ_ANALOG) begin
            ctl_nxt.analog_hiz = 1'b1;
        end else if (mode == cfg_latch_pkg::DRV_HIZ_DIG) begin
            ctl_nxt.digital_in = 1'b1;
        end else if (mode == cfg_latch_pkg::DRV_PULL_UP) begin
            ctl_nxt.pull_up = 1'b1;
        end else begin
            ctl_nxt.pull_down = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        ctl_r <= ctl_nxt;
    end

    assign ctl = ctl_r;

    a_mode_onehot: assert property (@(posedge clk) disable iff (!rst_b)
        $onehot({ctl.analog_hiz, ctl.digital_in, ctl.pull_up, ctl.pull_down}))
        else $error("drive controls not one-hot");

    a_mode_follow: assert property (@(posedge clk) disable iff (!rst_b)
        rst_b && mode == cfg_latch_pkg::DRV_PULL_DOWN |=> ctl.pull_down)
        else $error("pull-down code not decoded");

endmodule // drive_mode_decode

/* File: verilog/reset_config_latches.sv */
/*
 * Nonvolatile configuration latch array and the start-up configuration it
 * sets: port reset drive modes, shared reset pin, debug access and port,
 * boot clock speed, ECC region use with flash word check and correct, and
 * digital clock phase delay.
 * Assumes POR_B and RST_B are synchronous to MCLK, POR_B models power loss
 * of the latch array, and the shared pin is asynchronous.
 */
// The strobed register port was decided locally.
`timescale 1ns/100ps

// What this block does
// - Four latch bytes applied at every reset
// - Two-bit codes set each port's reset drive
// - Select bit makes shared pin GPIO or reset
// - Debug access blocked at 0, allowed at 1
// - Boot clock 12 MHz at 0, 48 MHz at 1
// - Debug port select: JTAG5, JTAG4, SWD, off
// - ECC enable reserves extra flash for codes
// - Four-bit field sets digital clock phase delay
// - With ECC on, flash reads checked and corrected
module reset_config_latches (
    input  wire logic                                MCLK,
    input  wire logic                                RST_B,
    input  wire logic                                POR_B,
    input  wire logic [cfg_latch_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic [cfg_latch_pkg::DATA_W-1:0]    WDATA,
    input  wire logic                                WR,
    input  wire logic                                RD,
    output      logic [cfg_latch_pkg::DATA_W-1:0]    RDATA,
    input  wire logic                                SHARED_PIN_IN,
    output      logic                                GPIO_IN_VAL,
    output      logic                                EXT_RESET_REQ,
    output cfg_latch_pkg::drive_ctl_t [cfg_latch_pkg::NUM_PORTS-1:0] PORT_DRIVE,
    output      logic                                DEBUG_ACCESS_EN,
    output cfg_latch_pkg::dbg_ports_t                DEBUG_PORTS,
    output      logic                                BOOT_CLK_48M,
    output      logic                                ECC_ENABLE,
    output      logic [3:0]                          CLK_PHASE_DLY,
    output      logic                                CFG_PENDING,
    input  cfg_latch_pkg::flash_word_t               FLASH_IN,
    output cfg_latch_pkg::flash_rsp_t                FLASH_OUT
);

    localparam int N = cfg_latch_pkg::NUM_LATCH;

    // Latch array and applied copy
    logic [7:0]                          latch_r   [N];
    logic [7:0]                          latch_nxt [N];
    logic [7:0]                          app_r     [N];
    logic [7:0]                          app_nxt   [N];
    logic [cfg_latch_pkg::WCNT_W-1:0]    wcnt_r;
    logic [cfg_latch_pkg::WCNT_W-1:0]    wcnt_nxt;
    logic [7:0]                          rdata_r;
    logic [7:0]                          rdata_nxt;
    logic                                pending;

    // Shared pin synchroniser and derived outputs
    logic                                pin_s1_r;
    logic                                pin_s2_r;
    logic                                gpio_r;
    logic                                gpio_nxt;
    logic                                xreq_r;
    logic                                xreq_nxt;
    cfg_latch_pkg::dbg_ports_t           dbg_r;
    cfg_latch_pkg::dbg_ports_t           dbg_nxt;

    // Flash path
    cfg_latch_pkg::flash_rsp_t           fl_r;
    cfg_latch_pkg::flash_rsp_t           fl_nxt;

    logic [2*cfg_latch_pkg::NUM_PORTS-1:0] modes;

    function automatic logic is_pow2(input int p);
        is_pow2 = ((p & (p - 1)) == 0);
    endfunction

    // Codeword bit 0 is the overall parity; parity bits sit at powers of two
    function automatic logic [cfg_latch_pkg::FL_CW_W-1:0] build_cw(
        input logic [cfg_latch_pkg::FL_DATA_W-1:0] d,
        input logic [cfg_latch_pkg::FL_ECC_W-1:0]  e);
        logic [cfg_latch_pkg::FL_CW_W-1:0] w;
        int                                k;
        int                                j;
        w = '0;
        k = 0;
        j = 0;
        w[0] = e[cfg_latch_pkg::FL_ECC_W-1];
        for (int p = 1; p < cfg_latch_pkg::FL_CW_W; p++) begin
            if (is_pow2(p)) begin
                w[p] = e[j];
                j++;
            end else begin
                w[p] = d[k];
                k++;
            end
        end
        build_cw = w;
    endfunction

    function automatic logic [cfg_latch_pkg::FL_DATA_W-1:0] extract_data(
        input logic [cfg_latch_pkg::FL_CW_W-1:0] w);
        logic [cfg_latch_pkg::FL_DATA_W-1:0] d;
        int                                  k;
        d = '0;
        k = 0;
        for (int p = 1; p < cfg_latch_pkg::FL_CW_W; p++) begin
            if (!is_pow2(p)) begin
                d[k] = w[p];
                k++;
            end
        end
        extract_data = d;
    endfunction

    function automatic logic [cfg_latch_pkg::FL_SYN_W-1:0] syndrome(
        input logic [cfg_latch_pkg::FL_CW_W-1:0] w);
        logic [cfg_latch_pkg::FL_SYN_W-1:0] s;
        s = '0;
        for (int p = 1; p < cfg_latch_pkg::FL_CW_W; p++) begin
            if (w[p]) begin
                s = s ^ cfg_latch_pkg::FL_SYN_W'(p);
            end
        end
        syndrome = s;
    endfunction

    // Latch programming, applied copy, counters and read port
    always_comb begin
        for (int i = 0; i < N; i++) begin
            latch_nxt[i] = latch_r[i];
            app_nxt[i]   = app_r[i];
        end
        wcnt_nxt  = wcnt_r;
        rdata_nxt = '0;
        if (!POR_B) begin
            latch_nxt[0] = cfg_latch_pkg::DEF_DRIVE_LOW;
            latch_nxt[1] = cfg_latch_pkg::DEF_DRIVE_HIGH;
            latch_nxt[2] = cfg_latch_pkg::DEF_RST_DBG;
            latch_nxt[3] = cfg_latch_pkg::DEF_BOOT_ECC;
            app_nxt[0]   = cfg_latch_pkg::DEF_DRIVE_LOW;
            app_nxt[1]   = cfg_latch_pkg::DEF_DRIVE_HIGH;
            app_nxt[2]   = cfg_latch_pkg::DEF_RST_DBG;
            app_nxt[3]   = cfg_latch_pkg::DEF_BOOT_ECC;
            wcnt_nxt     = '0;
        end else if (!RST_B) begin
            // Latches survive a reset; the applied copy reloads from them
            for (int i = 0; i < N; i++) begin
                app_nxt[i] = latch_r[i];
            end
        end else begin
            if (WR) begin
                if (ADDR == cfg_latch_pkg::IDX_DRIVE_LOW) begin
                    latch_nxt[0] = WDATA;
                end else if (ADDR == cfg_latch_pkg::IDX_DRIVE_HIGH) begin
                    latch_nxt[1] = WDATA;
                end else if (ADDR == cfg_latch_pkg::IDX_RST_DBG) begin
                    latch_nxt[2] = WDATA & cfg_latch_pkg::RST_DBG_WMASK;
                end else if (ADDR == cfg_latch_pkg::IDX_BOOT_ECC) begin
                    latch_nxt[3] = WDATA;
                end
                // Wear count so software can see how often latches were rewritten
                if (ADDR < cfg_latch_pkg::IDX_STATUS && wcnt_r != '1) begin
                    wcnt_nxt = wcnt_r + 1'b1;
                end
            end
            if (RD) begin
                if (ADDR < cfg_latch_pkg::IDX_STATUS) begin
                    rdata_nxt = latch_r[ADDR[1:0]];
                end else if (ADDR == cfg_latch_pkg::IDX_STATUS) begin
                    rdata_nxt[cfg_latch_pkg::STAT_PEND_BIT] = pending;
                end else if (ADDR == cfg_latch_pkg::IDX_WCOUNT) begin
                    rdata_nxt = wcnt_r;
                end else begin
                    rdata_nxt = '0;
                end
            end
        end
    end

    always_ff @(posedge MCLK) begin
        for (int i = 0; i < N; i++) begin
            latch_r[i] <= latch_nxt[i];
            app_r[i]   <= app_nxt[i];
        end
        wcnt_r  <= wcnt_nxt;
        rdata_r <= rdata_nxt;
    end

    always_comb begin
        pending = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (latch_r[i] != app_r[i]) begin
                pending = 1'b1;
            end
        end
    end

    // Shared pin, debug port decode
    always_comb begin
        gpio_nxt = 1'b0;
        xreq_nxt = 1'b0;
        dbg_nxt  = '0;
        if (RST_B) begin
            if (app_r[2][cfg_latch_pkg::EXT_RST_BIT]) begin
                xreq_nxt = !pin_s2_r;
            end else begin
                gpio_nxt = pin_s2_r;
            end
            if (app_r[2][cfg_latch_pkg::DBG_EN_BIT]) begin
                case (app_r[3][cfg_latch_pkg::DPS_HI:cfg_latch_pkg::DPS_LO])
                    cfg_latch_pkg::DPS_JTAG5: dbg_nxt.jtag5 = 1'b1;
                    cfg_latch_pkg::DPS_JTAG4: dbg_nxt.jtag4 = 1'b1;
                    cfg_latch_pkg::DPS_SWD:   dbg_nxt.swd   = 1'b1;
                    default:                  dbg_nxt       = '0;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK) begin
        pin_s1_r <= SHARED_PIN_IN;
        pin_s2_r <= pin_s1_r;
        gpio_r   <= gpio_nxt;
        xreq_r   <= xreq_nxt;
        dbg_r    <= dbg_nxt;
    end

    // Flash word check; bypass leaves the check byte free for data use
    always_comb begin
        logic [cfg_latch_pkg::FL_CW_W-1:0]  cw;
        logic [cfg_latch_pkg::FL_SYN_W-1:0] syn;
        logic                               odd;
        cw     = build_cw(FLASH_IN.data, FLASH_IN.ecc);
        syn    = syndrome(cw);
        odd    = ^cw;
        fl_nxt = '0;
        if (RST_B && FLASH_IN.valid) begin
            fl_nxt.valid = 1'b1;
            if (app_r[3][cfg_latch_pkg::ECC_EN_BIT]) begin
                if (odd) begin
                    cw[syn] = !cw[syn];
                    fl_nxt.corrected = 1'b1;
                end else if (syn != '0) begin
                    fl_nxt.dual_err = 1'b1;
                end
                fl_nxt.data = extract_data(cw);
            end else begin
                fl_nxt.data = FLASH_IN.data;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        fl_r <= fl_nxt;
    end

    // Port drive decoders, one per port
    assign modes = {app_r[2][1:0], app_r[1], app_r[0]};

    generate
        for (genvar g = 0; g < cfg_latch_pkg::NUM_PORTS; g++) begin : g_port
            drive_mode_decode u_dec (
                .clk  (MCLK),
                .rst_b(RST_B),
                .mode (modes[2*g+1:2*g]),
                .ctl  (PORT_DRIVE[g])
            );
        end
    endgenerate

    assign RDATA           = rdata_r;
    assign GPIO_IN_VAL     = gpio_r;
    assign EXT_RESET_REQ   = xreq_r;
    assign DEBUG_ACCESS_EN = app_r[2][cfg_latch_pkg::DBG_EN_BIT];
    assign DEBUG_PORTS     = dbg_r;
    assign BOOT_CLK_48M    = app_r[3][cfg_latch_pkg::BOOT_SPD_BIT];
    assign ECC_ENABLE      = app_r[3][cfg_latch_pkg::ECC_EN_BIT];
    assign CLK_PHASE_DLY   = app_r[3][cfg_latch_pkg::PHS_HI:cfg_latch_pkg::PHS_LO];
    assign CFG_PENDING     = pending;
    assign FLASH_OUT       = fl_r;

    default clocking cb @(posedge MCLK);
    endclocking

    default disable iff (!RST_B || !POR_B);

    a_apply_reset: assert property (disable iff (!POR_B)
        !RST_B |=> app_r[3] == $past(latch_r[3]) && app_r[0] == $past(latch_r[0]))
        else $error("applied copy not reloaded in reset");

    a_hold_run: assert property (
        RST_B ##1 RST_B |-> $stable(app_r[2]) && $stable(app_r[1]))
        else $error("applied copy changed outside reset");

    a_pin_gpio: assert property (
        !app_r[2][cfg_latch_pkg::EXT_RST_BIT] ##1 RST_B |-> !EXT_RESET_REQ)
        else $error("reset request while pin is GPIO");

    a_pin_reset: assert property (
        RST_B && app_r[2][cfg_latch_pkg::EXT_RST_BIT] && !pin_s2_r |=>
        EXT_RESET_REQ && !GPIO_IN_VAL)
        else $error("low reset pin not turned into request");

    a_debug_block: assert property (
        !DEBUG_ACCESS_EN ##1 RST_B |-> DEBUG_PORTS == '0)
        else $error("debug port open with access blocked");

    a_port_swd: assert property (
        RST_B && DEBUG_ACCESS_EN &&
        app_r[3][cfg_latch_pkg::DPS_HI:cfg_latch_pkg::DPS_LO] == cfg_latch_pkg::DPS_SWD
        |=> DEBUG_PORTS.swd && !DEBUG_PORTS.jtag4 && !DEBUG_PORTS.jtag5)
        else $error("SWD select not decoded");

    a_ecc_bypass: assert property (
        RST_B && FLASH_IN.valid && !ECC_ENABLE |=>
        FLASH_OUT.valid && FLASH_OUT.data == $past(FLASH_IN.data) && !FLASH_OUT.corrected)
        else $error("flash data altered with ECC off");

    a_ecc_flags: assert property (
        FLASH_OUT.valid |-> !(FLASH_OUT.corrected && FLASH_OUT.dual_err))
        else $error("single and double error flagged together");

    // Write, one idle cycle, then a reset pulse that applies the new byte
    a_byte3_layout: assert property (disable iff (!POR_B)
        RST_B && WR && ADDR == cfg_latch_pkg::IDX_BOOT_ECC ##1 RST_B && !WR ##1 !RST_B |=>
        CLK_PHASE_DLY == $past(WDATA[cfg_latch_pkg::PHS_HI:cfg_latch_pkg::PHS_LO], 3)
        && BOOT_CLK_48M == $past(WDATA[cfg_latch_pkg::BOOT_SPD_BIT], 3))
        else $error("byte three fields misplaced");

    a_read_slot: assert property (
        RD && ADDR == cfg_latch_pkg::IDX_WCOUNT |=> RDATA == $past(wcnt_r))
        else $error("read data not in following cycle");

    c_reload: cover property (disable iff (!POR_B) !RST_B ##1 RST_B && !CFG_PENDING);
    c_pending: cover property (WR && ADDR == cfg_latch_pkg::IDX_RST_DBG ##1 CFG_PENDING);
    c_correct: cover property (FLASH_OUT.valid && FLASH_OUT.corrected);
    c_ext_reset: cover property (EXT_RESET_REQ);

endmodule // reset_config_latches

/* File: verif/tb_top.sv */
/*
 * Self-checking bench for the reset configuration latch block: defaults,
 * latch writes applied only through reset, field decode, masked and
 * unmapped accesses, shared pin modes, wear count and flash check/correct.
 * Assumes the design's assertions live in the design files.
 */
`timescale 1ns/100ps

module tb_top;
    logic                              mclk = 1'b0, rst_b = 1'b0, por_b = 1'b0;
    logic [7:0]                        addr = 8'h00, wdata = 8'h00, rdata;
    logic                              wr = 1'b0, rd = 1'b0, pin = 1'b1;
    logic                              gpio_val, ext_req, dbg_en, boot_48m, ecc_en, pending;
    logic [3:0]                        phase;
    cfg_latch_pkg::drive_ctl_t [8:0]   drive;
    cfg_latch_pkg::dbg_ports_t         dports;
    cfg_latch_pkg::flash_word_t        fin = '0;
    cfg_latch_pkg::flash_rsp_t         fout;
    integer                            seed = 32'hd6818eec;
    int                                mismatches = 0, samples_checked = 0, cycles = 0;
    logic [31:0]                       cur, old, r;
    logic [71:0]                       c, c1, c2, w;
    logic [63:0]                       d;
    logic [31:0]                       corner [4] = '{32'hE41BFFF1, 32'h00FF3E0B,
                                                      32'hAA55C205, 32'h55AA410E};

    reset_config_latches uut (
        .MCLK(mclk), .RST_B(rst_b), .POR_B(por_b), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SHARED_PIN_IN(pin), .GPIO_IN_VAL(gpio_val),
        .EXT_RESET_REQ(ext_req), .PORT_DRIVE(drive), .DEBUG_ACCESS_EN(dbg_en),
        .DEBUG_PORTS(dports), .BOOT_CLK_48M(boot_48m), .ECC_ENABLE(ecc_en),
        .CLK_PHASE_DLY(phase), .CFG_PENDING(pending), .FLASH_IN(fin), .FLASH_OUT(fout)
    );

    always #5 mclk = ~mclk;

    // Run should take well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(string what, logic [71:0] seen, logic [71:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask

    // Reset pulse loads latches into the applied copy; decode lands two edges on
    task automatic apply(logic p);
        @(posedge mclk);
        rst_b <= 1'b0;
        pin <= p;
        @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    function automatic logic [3:0] drv_exp(logic [1:0] m);
        return 4'h8 >> m;
    endfunction

    function automatic logic [2:0] dbg_exp(logic en, logic [1:0] s);
        return en ? 3'h4 >> s : 3'h0;
    endfunction

    task automatic check_cfg(logic [31:0] cw);
        logic [1:0] m;
        check("dbg_en", dbg_en, cw[14]);
        check("dports", dports, dbg_exp(cw[14], cw[2:1]));
        check("boot_48m", boot_48m, cw[0]);
        check("ecc_en", ecc_en, cw[3]);
        check("phase", phase, cw[7:4]);
        check("gpio", gpio_val, cw[15] ? 1'b0 : pin);
        check("ext_req", ext_req, cw[15] & ~pin);
        for (int i = 0; i < 9; i++) begin
            m = (i < 4) ? cw[24+2*i +: 2] : ((i < 8) ? cw[16+2*(i-4) +: 2] : cw[9:8]);
            check("drive", drive[i], drv_exp(m));
        end
    endtask

    // Codeword: bit 0 overall parity, powers of two check bits, data elsewhere
    function automatic logic [71:0] enc(logic [63:0] dd);
        logic [71:0] cc;
        int j;
        cc = '0;
        j = 0;
        for (int k = 1; k < 72; k++)
            if ((k & (k - 1)) != 0) begin
                cc[k] = dd[j];
                j++;
            end
        for (int k = 0; k < 7; k++)
            for (int p = 1; p < 72; p++)
                if (((p >> k) & 1) == 1 && (p & (p - 1)) != 0)
                    cc[1 << k] ^= cc[p];
        cc[0] = ^cc[71:1];
        return cc;
    endfunction

    function automatic logic [71:0] split(logic [71:0] cc);
        logic [71:0] o;
        int j;
        j = 8;
        for (int k = 1; k < 72; k++)
            if ((k & (k - 1)) != 0) begin
                o[j] = cc[k];
                j++;
            end
        for (int k = 0; k < 7; k++)
            o[k] = cc[1 << k];
        o[7] = cc[0];
        return o;
    endfunction

    task automatic flash(logic [71:0] cc, logic [63:0] ed, logic ec, logic ee);
        @(posedge mclk);
        fin <= {1'b1, split(cc)};
        @(posedge mclk);
        fin.valid <= 1'b0;
        #1;
        check("fl_valid", fout.valid, 1'b1);
        check("fl_data", fout.data, ed);
        check("fl_cor", fout.corrected, ec);
        check("fl_dual", fout.dual_err, ee);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        por_b <= 1'b1;
        rst_b <= 1'b1;
        old = 32'h0000400A;
        @(posedge mclk);
        #1;
        check_cfg(old);
        for (int i = 0; i < 4; i++)
            rd_chk("latch_def", i, old[31-8*i -: 8]);
        rd_chk("wear_def", 8'h05, 8'h00);
        for (int k = 0; k < 8; k++) begin
            cur = (k < 4) ? corner[k] : $random(seed);
            for (int i = 0; i < 4; i++)
                wr_reg(i, cur[31-8*i -: 8]);
            #1;
            check("pending", pending, 1'b1);
            check_cfg(old);
            rd_chk("status", 8'h04, 8'h01);
            cur[15:8] &= 8'hC3;
            for (int i = 0; i < 4; i++)
                rd_chk("latch", i, cur[31-8*i -: 8]);
            r = $random(seed);
            apply(r[0]);
            check_cfg(cur);
            check("pending_clr", pending, 1'b0);
            old = cur;
        end
        // Unmapped and status writes are dropped and not counted
        wr_reg(8'h07, 8'hFF);
        wr_reg(8'h04, 8'hFF);
        rd_chk("unmapped", 8'h08, 8'h00);
        rd_chk("wear", 8'h05, 8'h20);
        rd_chk("latch_keep", 8'h03, old[7:0]);
        @(posedge mclk);
        #1;
        check("rdata_idle", rdata, 8'h00);
        old[7:0] = 8'hA8;
        wr_reg(8'h03, old[7:0]);
        apply(1'b1);
        check_cfg(old);
        for (int k = 0; k < 6; k++) begin
            d = {$random(seed), $random(seed)};
            c = enc(d);
            flash(c, d, 1'b0, 1'b0);
            c1 = c;
            c1[{$random(seed)} % 72] ^= 1'b1;
            flash(c1, d, 1'b1, 1'b0);
            c2 = c;
            c2[3] ^= 1'b1;
            c2[5] ^= 1'b1;
            w = split(c2);
            flash(c2, w[71:8], 1'b0, 1'b1);
        end
        // With the region released, a flipped bit must pass untouched
        old[7:0] = 8'h57;
        wr_reg(8'h03, old[7:0]);
        apply(1'b1);
        check_cfg(old);
        w = split(c1);
        flash(c1, w[71:8], 1'b0, 1'b0);
        wrap_up();
    end
endmodule // tb_top
